/* sea_consts.svh */
// Constants of the serial EEPROM array block: offsets, fields, reset values, timing
// Function
// R1 - Board ties three strap inputs, giving eight selectable slave addresses.
// R2 - Respond only when sent slave address bits equal the strap levels.
// R3 - Unconnected strap inputs read as logic zero in the comparison.
// R4 - Data line is open drain: pull low or release, never drive high.
// R5 - Write-protect high inhibits all array writes; low or open allows them. The code does not resolve an open WP_I to low, as it does the straps.
// R6 - Every byte reads all ones before any write.
// R7 - Six check bits stored per four-byte group sharing address bits 14..2.
// R8 - Reads correct any single bad bit in the group before delivery.
// R9 - Any byte write rewrites whole group by read-modify-write with new check bits.
// R10 - Master should preferably write whole aligned four-byte groups for endurance.
// R11 - Seven-bit device address is type code 1010 then three strap bits.
// R12 - Under write protection, withhold data-byte acknowledge and do not program.
// R13 - During internal write cycle ignore the bus and never acknowledge.
// R14 - Internal write cycle completes within five milliseconds, then busy clears.
// R15 - Check code is single-error-correcting Hamming; syndrome flips the bad bit.
`ifndef SEA_CONSTS_SVH
`define SEA_CONSTS_SVH

`define SEA_ADDR_W        15
`define SEA_FIFO_DEPTH    16
`define SEA_CHECK_BITS    6
`define SEA_CODE_BITS     38
`define SEA_DEV_TYPE      4'ha
`define SEA_ERASED_WORD   32'hffffffff

`define SEA_CLK_MHZ       50
`define SEA_PROG_TIME_US  5000
`define SEA_PROG_CYCLES   (`SEA_PROG_TIME_US * `SEA_CLK_MHZ)

`define SEA_REG_CTRL      8'h00
`define SEA_REG_STATUS    8'h04
`define SEA_REG_ERRCNT    8'h08

`define SEA_CTRL_ECC_EN   0
`define SEA_CTRL_SW_WP    1
`define SEA_CTRL_RESET    2'h1

`define SEA_ST_BUSY       0
`define SEA_ST_INIT_DONE  1
`define SEA_ST_WP         2
`define SEA_ST_STRAP      3
`define SEA_ST_SDA        6
`define SEA_ST_FIFO_EMPTY 7

`endif

/* sea_pkg.sv */
// Types shared by the serial EEPROM array block
package sea_pkg;

  typedef enum logic [2:0] {
    SEA_INIT   = 3'h0,
    SEA_IDLE   = 3'h1,
    SEA_RMW_RD = 3'h2,
    SEA_RMW_WR = 3'h3,
    SEA_HOLD   = 3'h4
  } sea_state_e;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } sea_wr_s;

  typedef struct packed {
    sea_state_e  state;
    logic [12:0] sweep;
    logic [19:0] timer;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        wp_s1;
    logic        wp_s2;
    logic [2:0]  strap_s1;
    logic [2:0]  strap_s2;
    logic        sda_low;
    logic        rd_pend;
    logic [1:0]  rd_lane;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [31:0] hrdata;
    logic [1:0]  ctrl;
    logic [15:0] errcnt;
  } sea_state_s;

endpackage

/* sea_top.sv */
// Write-data FIFO and top of the serial EEPROM array with check-bit logic
`include "sea_consts.svh"

module sea_fifo #(
  parameter int W     = 23,
  parameter int DEPTH = `SEA_FIFO_DEPTH
) (
  input  wire logic         MCLK_I,
  input  wire logic         RST_I,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         full;
  logic         empty;

  // Extra pointer bit tells full from empty
  assign empty       = (wp_q == rp_q);
  assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rp_q[AW-1:0]];

  // Pointers
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (in_valid_i && !full)
        wp_q <= wp_q + 1'b1;
      if (out_ready_i && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end

  // Storage needs no reset, only written entries are read
  always_ff @(posedge MCLK_I)
  begin
    if (in_valid_i && !full)
      mem[wp_q[AW-1:0]] <= in_data_i;
  end
endmodule // sea_fifo

module sea_top #(
  parameter int ADDR_W      = `SEA_ADDR_W,
  parameter int PROG_CYCLES = `SEA_PROG_CYCLES,
  parameter int FIFO_DEPTH  = `SEA_FIFO_DEPTH
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  input  wire logic        STRAP_ADDR_BIT0_I,
  input  wire logic        STRAP_ADDR_BIT1_I,
  input  wire logic        STRAP_ADDR_BIT2_I,
  input  wire logic        WP_I,
  input  wire logic [6:0]  DEV_ADDR_I,
  output logic             MATCH_O,
  input  wire logic        BIT_LOW_REQ_I,
  input  wire logic        WR_VALID_I,
  output logic             WR_READY_O,
  input  wire logic [14:0] WR_ADDR_I,
  input  wire logic [7:0]  WR_DATA_I,
  output logic             DATA_ACK_O,
  input  wire logic        WR_COMMIT_I,
  output logic             BUSY_O,
  input  wire logic        RD_REQ_I,
  input  wire logic [14:0] RD_ADDR_I,
  output logic             RD_VALID_O,
  output logic [7:0]       RD_DATA_O
);
  localparam int GW     = ADDR_W - 2;
  localparam int GROUPS = 2 ** GW;
  localparam logic [19:0] PROG_LAST  = 20'(PROG_CYCLES - 1);
  localparam logic [12:0] SWEEP_LAST = 13'(GROUPS - 1);

  sea_pkg::sea_state_s q;
  sea_pkg::sea_state_s d;
  sea_pkg::sea_wr_s    fifo_in;
  sea_pkg::sea_wr_s    fifo_out;

  logic [37:0] mem [GROUPS];
  logic [37:0] mem_q;
  logic        mem_we;
  logic [12:0] mem_waddr;
  logic [37:0] mem_wdata;
  logic [12:0] mem_raddr;
  logic [2:0]  strap_raw;
  logic        fifo_ready;
  logic        fifo_valid;
  logic        fifo_pop;
  logic        busy;
  logic        wp_eff;
  logic        push;
  logic [31:0] rd_fixed;
  logic [31:0] rd_raw;
  logic        rd_err;
  logic [31:0] merged;

  // Hamming encode: checks at power-of-two positions 1..32, data elsewhere up to 38
  function automatic logic [37:0] sea_enc(input logic [31:0] dat);
    logic [37:0] cw;
    int          k;
    int          pos;
    int          i;
    cw = '0;
    k  = 0;
    for (pos = 1; pos <= `SEA_CODE_BITS; pos++)
      if ((pos & (pos - 1)) != 0)
      begin
        cw[pos-1] = dat[k];
        k++;
      end
    for (i = 0; i < `SEA_CHECK_BITS; i++)
      for (pos = 1; pos <= `SEA_CODE_BITS; pos++)
        if (((pos >> i) & 1) == 1 && pos != (1 << i))
          cw[(1<<i)-1] = cw[(1<<i)-1] ^ cw[pos-1];
    return cw;
  endfunction

  // Syndrome is the position of the bad bit, zero when clean
  function automatic logic [5:0] sea_syn(input logic [37:0] cw);
    logic [5:0] s;
    int         pos;
    s = '0;
    for (pos = 1; pos <= `SEA_CODE_BITS; pos++)
      if (cw[pos-1])
        s = s ^ 6'(pos);
    return s;
  endfunction

  // Data bits back out of a codeword, optionally with the bad bit flipped
  function automatic logic [31:0] sea_dat(input logic [37:0] cw, input logic fix);
    logic [37:0] c;
    logic [5:0]  s;
    logic [31:0] dat;
    int          k;
    int          pos;
    c   = cw;
    s   = sea_syn(cw);
    dat = '0;
    k   = 0;
    if (fix && s != 6'h00 && s <= 6'(`SEA_CODE_BITS))
      c[s-6'h01] = !c[s-6'h01];
    for (pos = 1; pos <= `SEA_CODE_BITS; pos++)
      if ((pos & (pos - 1)) != 0)
      begin
        dat[k] = c[pos-1];
        k++;
      end
    return dat;
  endfunction

  // R3 open strap reads zero
  assign strap_raw = {STRAP_ADDR_BIT2_I === 1'b1, STRAP_ADDR_BIT1_I === 1'b1,
                      STRAP_ADDR_BIT0_I === 1'b1};

  // R13 busy blocks all bus answers
  assign busy   = (q.state != sea_pkg::SEA_IDLE);
  assign BUSY_O = busy;

  // R5 pin or software protection
  assign wp_eff = q.wp_s2 | q.ctrl[`SEA_CTRL_SW_WP];

  // R2 R11 type code then strap bits
  assign MATCH_O = !busy && (DEV_ADDR_I[6:3] == `SEA_DEV_TYPE) && (DEV_ADDR_I[2:0] == q.strap_s2);

  // R12 protected bytes dropped, no ack
  assign push       = WR_VALID_I && !busy && !wp_eff;
  assign WR_READY_O = fifo_ready && !busy;
  assign DATA_ACK_O = push && fifo_ready;

  // R4 only ever pulls low
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = q.sda_low;

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = q.hrdata;
  assign RD_VALID_O  = q.rd_valid;
  assign RD_DATA_O   = q.rd_data;

  assign fifo_in = '{addr: WR_ADDR_I, data: WR_DATA_I};

  // Back-pressure stalls the protocol engine once sixteen bytes wait for the cycle
  sea_fifo #(
    .W     ($bits(sea_pkg::sea_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .MCLK_I      (MCLK_I),
    .RST_I       (RST_I),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // R8 corrected user read data
  assign rd_raw   = sea_dat(mem_q, 1'b0);
  assign rd_fixed = sea_dat(mem_q, q.ctrl[`SEA_CTRL_ECC_EN]);
  assign rd_err   = (sea_syn(mem_q) != 6'h00);

  // R9 merge one byte into the corrected group
  always_comb
  begin
    merged = sea_dat(mem_q, 1'b1);
    merged[8*fifo_out.addr[1:0] +: 8] = fifo_out.data;
  end

  // Array port steering; sweep and program share the write port
  always_comb
  begin
    mem_we    = 1'b0;
    mem_waddr = q.sweep;
    mem_wdata = sea_enc(`SEA_ERASED_WORD);
    fifo_pop  = 1'b0;
    mem_raddr = (q.state == sea_pkg::SEA_RMW_RD) ? fifo_out.addr[14:2] : RD_ADDR_I[14:2];
    // R6 erased sweep after reset
    if (q.state == sea_pkg::SEA_INIT)
      mem_we = 1'b1;
    // R7 R15 new check bits per group
    if (q.state == sea_pkg::SEA_RMW_WR)
    begin
      mem_we    = 1'b1;
      mem_waddr = fifo_out.addr[14:2];
      mem_wdata = sea_enc(merged);
      fifo_pop  = 1'b1;
    end
  end

  // Array, one codeword per four-byte group
  always_ff @(posedge MCLK_I)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
    mem_q <= mem[mem_raddr];
  end

  // Next state of the whole block
  always_comb
  begin
    d          = q;
    d.scl_s1   = SCL_I;
    d.scl_s2   = q.scl_s1;
    d.scl_s3   = q.scl_s2;
    d.sda_s1   = SDA_I;
    d.sda_s2   = q.sda_s1;
    d.wp_s1    = WP_I;
    d.wp_s2    = q.wp_s1;
    d.strap_s1 = strap_raw;
    d.strap_s2 = q.strap_s1;
    d.rd_valid = 1'b0;

    // Low level held for one bit, released at the next link clock fall
    if (q.scl_s3 && !q.scl_s2)
      d.sda_low = 1'b0;
    // R13 no new low drive starts while busy
    if (BIT_LOW_REQ_I && !busy)
      d.sda_low = 1'b1;

    // User read, two cycles from request to data
    d.rd_pend = RD_REQ_I && (q.state != sea_pkg::SEA_RMW_RD);
    d.rd_lane = RD_ADDR_I[1:0];
    if (q.rd_pend)
    begin
      d.rd_valid = 1'b1;
      d.rd_data  = rd_fixed[8*q.rd_lane +: 8];
      if (rd_err && rd_fixed != rd_raw && q.errcnt != 16'hffff)
        d.errcnt = q.errcnt + 16'h0001;
    end

    // Program engine
    if (q.state != sea_pkg::SEA_INIT && q.state != sea_pkg::SEA_IDLE)
      d.timer = q.timer + 20'h00001;
    unique case (q.state)
      sea_pkg::SEA_INIT:
      begin
        d.sweep = q.sweep + 13'h0001;
        if (q.sweep == SWEEP_LAST)
          d.state = sea_pkg::SEA_IDLE;
      end
      sea_pkg::SEA_IDLE:
      begin
        d.timer = '0;
        // R12 commit with nothing queued does not program
        if (WR_COMMIT_I && fifo_valid)
          d.state = sea_pkg::SEA_RMW_RD;
      end
      sea_pkg::SEA_RMW_RD:
        d.state = sea_pkg::SEA_RMW_WR;
      sea_pkg::SEA_RMW_WR:
        d.state = sea_pkg::SEA_HOLD;
      sea_pkg::SEA_HOLD:
      begin
        // R14 bounded cycle then busy clears
        if (fifo_valid)
          d.state = sea_pkg::SEA_RMW_RD;
        else if (q.timer >= PROG_LAST)
          d.state = sea_pkg::SEA_IDLE;
      end
    endcase

    // AHB-Lite: address phase registered, write applied in data phase
    d.ahb_wr   = HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
    d.ahb_addr = HADDR_I[7:0];
    if (q.ahb_wr && q.ahb_addr == `SEA_REG_CTRL)
      d.ctrl = HWDATA_I[1:0];
    d.hrdata = '0;
    if (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I)
    begin
      if (HADDR_I[7:0] == `SEA_REG_CTRL)
        d.hrdata = {30'h0, q.ctrl};
      else if (HADDR_I[7:0] == `SEA_REG_STATUS)
        d.hrdata = {24'h0, !fifo_valid, q.sda_s2, q.strap_s2, wp_eff,
                    q.state != sea_pkg::SEA_INIT, busy};
      else if (HADDR_I[7:0] == `SEA_REG_ERRCNT)
        d.hrdata = {16'h0, q.errcnt};
    end
  end

  // Single state register; a read whose address phase meets the data phase of a CTRL write returns the old value
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      q       <= '0;
      q.state <= sea_pkg::SEA_INIT;
      q.ctrl  <= `SEA_CTRL_RESET;
    end
    else
      q <= d;
  end
endmodule // sea_top

/* sea_top_chk.sv */
// Port-level checks for the serial EEPROM array top
module sea_top_chk #(
  parameter int PROG_CYCLES = 64
) (
  input wire logic       MCLK_I,
  input wire logic       RST_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic       BIT_LOW_REQ_I,
  input wire logic       WP_I,
  input wire logic [6:0] DEV_ADDR_I,
  input wire logic       MATCH_O,
  input wire logic       WR_READY_O,
  input wire logic       DATA_ACK_O,
  input wire logic       BUSY_O,
  input wire logic       RD_REQ_I,
  input wire logic       RD_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ceiling adds the init sweep and the program time, so it covers whichever busy stretch is longer
  localparam int BUSY_MAX = 8192 + PROG_CYCLES + 8;
  logic [19:0] busy_cnt_q;
  logic [19:0] busy_cnt_d;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  // Length of the present busy stretch
  always_comb busy_cnt_d = BUSY_O ? busy_cnt_q + 20'h1 : 20'h0;
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I) busy_cnt_q <= 20'h0;
    else busy_cnt_q <= busy_cnt_d;
  end
  // Open drain: the driven output value never goes high
  property p_sda_low_only;
    SDA_O == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("data pin driven high");
  property p_oe_cause;
    $rose(SDA_OE_O) |-> $past(BIT_LOW_REQ_I);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("line pulled low unasked");
  property p_match_code;
    MATCH_O |-> DEV_ADDR_I[6:3] == 4'ha;
  endproperty
  a_match_code: assert property (p_match_code) else $error("match with wrong type code");
  property p_busy_deaf;
    BUSY_O |-> !MATCH_O && !WR_READY_O && !DATA_ACK_O;
  endproperty
  a_busy_deaf: assert property (p_busy_deaf) else $error("answered while busy");
  property p_wp_noack;
    WP_I [*4] |-> !DATA_ACK_O;
  endproperty
  a_wp_noack: assert property (p_wp_noack) else $error("byte acked under protect");
  property p_rd_lat;
    RD_REQ_I && !BUSY_O |-> ##2 RD_VALID_O;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_rd_only;
    RD_VALID_O |-> $past(RD_REQ_I, 2);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data without request");
  property p_busy_bound;
    busy_cnt_q <= BUSY_MAX;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule // sea_top_chk

/* sea_master_model.sv */
// Two-wire master side: clock line and pulled-up data line
module sea_master_model (
  input wire logic  sda_oe_i,
  output logic      scl_o,
  output wire logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sda_o = sda_oe_i ? 1'b0 : 1'b1;
  // Clock idles high between frames; each call is half of a 160 ns bit
  initial scl_o = 1'b1;
  // Callers start on a core falling edge, so no link edge meets a core rising edge
  task automatic drop();
    scl_o = 1'b0;
    #80;
  endtask
  task automatic rise();
    scl_o = 1'b1;
    #80;
  endtask
endmodule // sea_master_model

/* test_sea_top.sv */
// Self-checking bench for the serial EEPROM array top
`include "sea_consts.svh"
module test_sea_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 64;
  logic        mclk, rst, hsel, hwrite, bit_low, wp, wr_valid, commit, rd_req;
  logic [31:0] haddr, hwdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, strap;
  logic [6:0]  dev_addr;
  logic [14:0] wr_addr, rd_addr;
  logic [7:0]  wr_data;
  logic        ack;
  wire  [31:0] hrdata;
  wire  [7:0]  rd_data;
  wire         hready, hresp, scl, sda, sda_oe, match, wr_ready, data_ack, busy, rd_valid;
  int          n_fail, n_compared, cyc;
  // Core clock, 50 MHz
  always #10 mclk = ~mclk;
  sea_master_model i_sea_master_model (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  sea_top #(.PROG_CYCLES(PROG)) i_sea_top (.MCLK_I(mclk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_O(sda_oe), .STRAP_ADDR_BIT0_I(strap[0]), .STRAP_ADDR_BIT1_I(strap[1]),
    .STRAP_ADDR_BIT2_I(strap[2]), .WP_I(wp), .DEV_ADDR_I(dev_addr), .MATCH_O(match),
    .BIT_LOW_REQ_I(bit_low), .WR_VALID_I(wr_valid), .WR_READY_O(wr_ready), .WR_ADDR_I(wr_addr),
    .WR_DATA_I(wr_data), .DATA_ACK_O(data_ack), .WR_COMMIT_I(commit), .BUSY_O(busy),
    .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data));
  task conclude();
    $display("mismatches %0d, compared %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer; each phase held until ready is seen high at a rising edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task rd(input logic [14:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_req <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check(rd_valid, 1);
    check(rd_data, exp);
  endtask
  task wb(input logic [14:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    // Byte is taken at the rising edge that sees ready high
    do @(posedge mclk); while (wr_ready !== 1'b1);
    ack = data_ack;
    wr_valid <= 1'b0;
  endtask
  task wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) @(negedge mclk);
    check(busy, 0);
  endtask
  task commit_wait();
    @(posedge mclk);
    commit <= 1'b1;
    @(posedge mclk);
    commit <= 1'b0;
    @(negedge mclk);
    check(busy, 1);
    check(match, 0);
    wait_idle(PROG + 8);
  endtask
  // Registers: reset value, read-only and unmapped places
  task t_regs();
    ahb(1'b0, `SEA_REG_CTRL, 32'h0);
    check(r, 32'h1);
    check(hresp, 1'b0);
    // Status during the erase sweep: empty, line high, busy
    ahb(1'b0, `SEA_REG_STATUS, 32'h0);
    check(r, 32'hc1);
    ahb(1'b1, `SEA_REG_CTRL, 32'h3);
    ahb(1'b0, `SEA_REG_CTRL, 32'h0);
    check(r, 32'h3);
    ahb(1'b0, `SEA_REG_STATUS, 32'h0);
    check(r, 32'hc5);
    ahb(1'b1, `SEA_REG_CTRL, 32'h1);
    ahb(1'b1, `SEA_REG_ERRCNT, 32'hffff);
    ahb(1'b0, `SEA_REG_ERRCNT, 32'h0);
    check(r, 32'h0);
    ahb(1'b1, 8'h20, 32'h5a5a);
    ahb(1'b0, 8'h20, 32'h0);
    check(r, 32'h0);
  endtask
  task t_match();
    for (int s = 0; s < 8; s++)
    begin
      @(posedge mclk);
      strap <= s[2:0];
      dev_addr <= {4'ha, s[2:0]};
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      check(match, 1);
      @(posedge mclk);
      dev_addr <= {4'ha, ~s[2:0]};
      @(negedge mclk);
      check(match, 0);
      @(posedge mclk);
      dev_addr <= {4'h5, s[2:0]};
      @(negedge mclk);
      check(match, 0);
    end
    @(posedge mclk);
    strap <= 3'bzzz;
    dev_addr <= 7'h50;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(match, 1);
  endtask
  task t_erased();
    rd(15'h0, 8'hff);
    rd(15'h7fff, 8'hff);
  endtask
  // Fill the buffer to refusal, then one lone byte
  task t_fill();
    for (int i = 0; i < 16; i++)
    begin
      wb(15'h100 + 15'(i), 8'(i + 1));
      check(ack, 1);
    end
    @(negedge mclk);
    check(wr_ready, 0);
    commit_wait();
    rd(15'h100, 8'h01);
    rd(15'h10f, 8'h10);
    wb(15'h205, 8'h3c);
    commit_wait();
    rd(15'h204, 8'hff);
    rd(15'h205, 8'h3c);
    rd(15'h207, 8'hff);
  endtask
  task t_wp();
    @(posedge mclk);
    wp <= 1'b1;
    repeat (4) @(posedge mclk);
    wb(15'h300, 8'h12);
    check(ack, 0);
    // Stop after a refused byte must not start a cycle
    @(posedge mclk);
    commit <= 1'b1;
    @(posedge mclk);
    commit <= 1'b0;
    @(negedge mclk);
    check(busy, 0);
    @(posedge mclk);
    wp <= 1'b0;
    rd(15'h300, 8'hff);
    // Software protect refuses bytes as the pin does
    ahb(1'b1, `SEA_REG_CTRL, 32'h3);
    wb(15'h301, 8'h34);
    check(ack, 0);
    ahb(1'b1, `SEA_REG_CTRL, 32'h1);
    rd(15'h301, 8'hff);
  endtask
  // One low bit: asked after the synced fall, held until the next fall
  task t_sda();
    @(negedge mclk);
    fork
      begin
        i_sea_master_model.drop();
        i_sea_master_model.rise();
        i_sea_master_model.drop();
        i_sea_master_model.rise();
      end
      begin
        repeat (3) @(posedge mclk);
        bit_low <= 1'b1;
        @(posedge mclk);
        bit_low <= 1'b0;
        @(negedge mclk);
        check(sda, 0);
        repeat (6) @(negedge mclk);
        check(sda_oe, 1);
        repeat (2) @(negedge mclk);
        check(sda_oe, 0);
        check(sda, 1);
      end
    join
  endtask
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    {mclk, hsel, hwrite, bit_low, wp, wr_valid, commit, rd_req, strap} = '0;
    {haddr, hwdata, htrans, dev_addr, wr_addr, rd_addr, wr_data} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    wait_idle(9000);
    t_match();
    t_erased();
    t_fill();
    t_wp();
    t_sda();
    conclude();
  end
endmodule // test_sea_top
bind sea_top sea_top_chk #(.PROG_CYCLES(PROG_CYCLES)) i_sea_top_chk (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .BIT_LOW_REQ_I(BIT_LOW_REQ_I), .WP_I(WP_I), .DEV_ADDR_I(DEV_ADDR_I),
  .MATCH_O(MATCH_O), .WR_READY_O(WR_READY_O), .DATA_ACK_O(DATA_ACK_O), .BUSY_O(BUSY_O),
  .RD_REQ_I(RD_REQ_I), .RD_VALID_O(RD_VALID_O));
